/* logic/epoc_consts.svh */
// constants for the energy pulse output controller
`ifndef EPOC_CONSTS_SVH
`define EPOC_CONSTS_SVH
`define EPOC_CLK_MHZ 100
`define EPOC_SLOW_WIDTH_MS 275
`define EPOC_CAL_WIDTH_MS 90
`define EPOC_SLOW_WIDTH_CYC (`EPOC_SLOW_WIDTH_MS * 1000 * `EPOC_CLK_MHZ)
`define EPOC_CAL_WIDTH_CYC (`EPOC_CAL_WIDTH_MS * 1000 * `EPOC_CLK_MHZ)
`define EPOC_ACC_W 48
`define EPOC_CAL_DIV_LO 4'h4
`define EPOC_CAL_DIV_HI 4'h5
`define EPOC_RATE_SH0 4'hC
`define EPOC_RATE_SH1 4'hB
`define EPOC_RATE_SH2 4'hA
`define EPOC_RATE_SH3 4'h9
`endif

/* logic/epoc_pkg.sv */
// types for the energy pulse output controller
package epoc_pkg;
  typedef struct packed {
    logic cal_rate_select;
    logic rate_select_hi;
    logic rate_select_lo;
    logic gain_select_hi;
    logic gain_select_lo;
  } epoc_cfg_s;
  typedef struct packed {
    logic signed [31:0] power;
    logic valid;
  } epoc_sample_s;
  typedef enum logic [1:0] {EPOC_IDLE, EPOC_HIGH} epoc_pulse_e;
endpackage

/* logic/epoc_pulse_timer.sv */
// fixed-width pulse stretcher used for each pulse output
`timescale 1ns/1ps
`default_nettype none
module epoc_pulse_timer #(
  parameter int unsigned WIDTH_CYC = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // trigger and output
  input wire logic fire,
  output logic active
);
  import epoc_pkg::*;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  epoc_pulse_e st_reg;
  epoc_pulse_e st_next;
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    unique case (st_reg)
      EPOC_IDLE: begin
        if (fire) begin
          st_next = EPOC_HIGH;
          cnt_next = 32'(WIDTH_CYC - 1);
        end
      end
      EPOC_HIGH: begin
        if (cnt_reg == 32'h0) begin
          st_next = EPOC_IDLE;
        end else begin
          cnt_next = cnt_reg - 32'h1;
        end
      end
      default: st_next = EPOC_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= EPOC_IDLE;
      cnt_reg <= 32'h0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
    end
  end
  assign active = (st_reg == EPOC_HIGH);
endmodule
`default_nettype wire

/* logic/epoc_top.sv */
// energy pulse output controller: gain, rate select, accumulation and pulse outputs
`timescale 1ns/1ps
`default_nettype none
`include "epoc_consts.svh"
module epoc_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // strapped configuration
  input wire epoc_pkg::epoc_cfg_s cfg,
  // product samples from the multiplier front end (voltage times raw current)
  input wire epoc_pkg::epoc_sample_s sample,
  // pulse outputs
  output logic cal_pulse_out,
  output logic slow_pulse_out_a,
  output logic slow_pulse_out_b,
  output logic reverse_power_flag
);
  import epoc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] rate_shift(input logic hi, input logic lo);
    unique case ({hi, lo})
      2'b00: rate_shift = `EPOC_RATE_SH0;
      2'b01: rate_shift = `EPOC_RATE_SH1;
      2'b10: rate_shift = `EPOC_RATE_SH2;
      default: rate_shift = `EPOC_RATE_SH3;
    endcase
  endfunction

  function automatic logic [2:0] gain_shift(input logic hi, input logic lo);
    unique case ({hi, lo})
      2'b00: gain_shift = 3'h0;
      2'b01: gain_shift = 3'h1;
      2'b10: gain_shift = 3'h3;
      default: gain_shift = 3'h4;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // gain stage and magnitude
  logic signed [`EPOC_ACC_W-1:0] scaled;
  logic [`EPOC_ACC_W-1:0] mag;
  logic [4:0] slow_sh;
  logic [4:0] cal_sh;
  always_comb begin
    // gain of 1, 2, 8 or 16 as a left shift
    scaled = `EPOC_ACC_W'(sample.power) <<< gain_shift(cfg.gain_select_hi, cfg.gain_select_lo);
    mag = scaled[`EPOC_ACC_W-1] ? `EPOC_ACC_W'(-scaled) : `EPOC_ACC_W'(scaled);
    slow_sh = {1'b0, rate_shift(cfg.rate_select_hi, cfg.rate_select_lo)} + 5'h10;
    // calibration threshold is 1/16 or 1/32 of the slow one, chosen by cal_rate_select
    cal_sh = slow_sh - (cfg.cal_rate_select ? 5'(`EPOC_CAL_DIV_HI) : 5'(`EPOC_CAL_DIV_LO));
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulators: long one for the slow outputs, short one for calibration
  logic [`EPOC_ACC_W-1:0] slow_acc_reg;
  logic [`EPOC_ACC_W-1:0] slow_acc_next;
  logic [`EPOC_ACC_W-1:0] cal_acc_reg;
  logic [`EPOC_ACC_W-1:0] cal_acc_next;
  logic neg_reg;
  logic neg_next;
  logic slow_fire;
  logic cal_fire;
  logic [`EPOC_ACC_W-1:0] slow_thr;
  logic [`EPOC_ACC_W-1:0] cal_thr;
  always_comb begin
    slow_thr = `EPOC_ACC_W'(1) << slow_sh;
    cal_thr = `EPOC_ACC_W'(1) << cal_sh;
    slow_acc_next = slow_acc_reg;
    cal_acc_next = cal_acc_reg;
    neg_next = neg_reg;
    slow_fire = 1'b0;
    cal_fire = 1'b0;
    if (sample.valid) begin
      // accumulate magnitude; direction is tracked separately
      slow_acc_next = slow_acc_reg + mag;
      cal_acc_next = cal_acc_reg + mag;
      neg_next = scaled[`EPOC_ACC_W-1];
    end
    // half threshold: each crossing toggles a and b alternately
    if (slow_acc_next >= (slow_thr >> 1)) begin
      slow_acc_next = slow_acc_next - (slow_thr >> 1);
      slow_fire = 1'b1;
    end
    if (cal_acc_next >= cal_thr) begin
      cal_acc_next = cal_acc_next - cal_thr;
      cal_fire = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase select and output registers
  logic phase_reg;
  logic phase_next;
  logic rev_reg;
  logic rev_next;
  logic fire_a;
  logic fire_b;
  logic act_a;
  logic act_b;
  logic act_c;
  always_comb begin
    phase_next = slow_fire ? ~phase_reg : phase_reg;
    fire_a = slow_fire && !phase_reg;
    fire_b = slow_fire && phase_reg;
    // flag follows sign only at a calibration pulse and holds it until the next one
    // a crossing dropped while the cal timer runs issues no pulse, so it must not move the flag
    rev_next = (cal_fire && !act_c) ? neg_next : rev_reg;
  end

  epoc_pulse_timer #(.WIDTH_CYC(`EPOC_SLOW_WIDTH_CYC)) u_pulse_a (
    .clk(clk), .rst_n(rst_n), .fire(fire_a), .active(act_a)
  );
  epoc_pulse_timer #(.WIDTH_CYC(`EPOC_SLOW_WIDTH_CYC)) u_pulse_b (
    .clk(clk), .rst_n(rst_n), .fire(fire_b), .active(act_b)
  );
  epoc_pulse_timer #(.WIDTH_CYC(`EPOC_CAL_WIDTH_CYC)) u_pulse_c (
    .clk(clk), .rst_n(rst_n), .fire(cal_fire), .active(act_c)
  );

  // reset returns everything to idle, with the slow outputs high, so no pulse can start while held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slow_acc_reg <= '0;
      cal_acc_reg <= '0;
      neg_reg <= 1'b0;
      phase_reg <= 1'b0;
      rev_reg <= 1'b0;
      cal_pulse_out <= 1'b0;
      slow_pulse_out_a <= 1'b1;
      slow_pulse_out_b <= 1'b1;
      reverse_power_flag <= 1'b0;
    end else begin
      slow_acc_reg <= slow_acc_next;
      cal_acc_reg <= cal_acc_next;
      neg_reg <= neg_next;
      phase_reg <= phase_next;
      rev_reg <= rev_next;
      // outputs lag the timers by one edge; flag kept in step with cal pulse
      cal_pulse_out <= act_c;
      slow_pulse_out_a <= ~act_a;
      slow_pulse_out_b <= ~act_b;
      reverse_power_flag <= rev_reg;
    end
  end
endmodule
`default_nettype wire

/* verification/epoc_counter_model.sv */
// step counter standing at the two slow outputs
`timescale 1ns/1ps
`default_nettype none
module epoc_counter_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // coil drives, active low
  input wire logic pulse_a,
  input wire logic pulse_b,
  // steps since reset
  output logic [7:0] n_steps
);
  logic a_reg = 1'b1, b_reg = 1'b1;
  // one step per falling drive edge; a level alone moves nothing
  always @(posedge clk) begin
    a_reg <= pulse_a;
    b_reg <= pulse_b;
    if (!rst_n)
      n_steps <= 8'h00;
    else
      n_steps <= n_steps + {7'h00, a_reg & ~pulse_a} + {7'h00, b_reg & ~pulse_b};
  end
endmodule
`default_nettype wire

/* verification/epoc_top_chk.sv */
// port assertions for the pulse output controller
`timescale 1ns/1ps
`default_nettype none
module epoc_top_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sample input
  input wire epoc_pkg::epoc_sample_s sample,
  // pulse outputs
  input wire logic cal_pulse_out,
  input wire logic slow_pulse_out_a,
  input wire logic slow_pulse_out_b,
  input wire logic reverse_power_flag
);
  import epoc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_cal_rise; $rose(cal_pulse_out); endsequence
  // widths are millions of cycles, so only the first eight are held to account
  property p_quiet; disable iff (1'b0) !rst_n |=> !cal_pulse_out && slow_pulse_out_a
    && slow_pulse_out_b && !reverse_power_flag; endproperty
  a_quiet: assert property (p_quiet) else $error("pulse in reset");
  property p_flag_at_cal; $changed(reverse_power_flag) |-> $rose(cal_pulse_out); endproperty
  a_flag_at_cal: assert property (p_flag_at_cal) else $error("flag moved alone");
  property p_flag_sign; s_cal_rise |-> reverse_power_flag == $past(sample.power[31], 2); endproperty
  a_flag_sign: assert property (p_flag_sign) else $error("flag sign");
  property p_cal_cause; s_cal_rise |-> $past(sample.valid, 2); endproperty
  a_cal_cause: assert property (p_cal_cause) else $error("cal cause");
  property p_cal_hold; s_cal_rise |=> cal_pulse_out [*8]; endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("cal width");
  property p_a_hold; $fell(slow_pulse_out_a) |=> !slow_pulse_out_a [*8]; endproperty
  a_a_hold: assert property (p_a_hold) else $error("a width");
  property p_b_hold; $fell(slow_pulse_out_b) |=> !slow_pulse_out_b [*8]; endproperty
  a_b_hold: assert property (p_b_hold) else $error("b width");
  property p_alt; $fell(slow_pulse_out_a) |-> !$fell(slow_pulse_out_b); endproperty
  a_alt: assert property (p_alt) else $error("a and b together");
endmodule
bind epoc_top epoc_top_chk chk_u (.clk(clk), .rst_n(rst_n), .sample(sample),
  .cal_pulse_out(cal_pulse_out), .slow_pulse_out_a(slow_pulse_out_a),
  .slow_pulse_out_b(slow_pulse_out_b), .reverse_power_flag(reverse_power_flag));
`default_nettype wire

/* verification/tb_epoc_top.sv */
// self-checking bench for the pulse output controller
`timescale 1ns/1ps
`default_nettype none
module tb_epoc_top;
  import epoc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0;
  epoc_cfg_s cfg = '0;
  epoc_sample_s sample = '0;
  logic cal, sa, sb, flg;
  logic pc = 1'b0, pa = 1'b1, pb = 1'b1;
  logic [7:0] steps;
  logic [31:0] lf = 32'hD6E2;
  logic [7:0] q[$];
  int err_count = 0, n_compared = 0;
  epoc_top dut_u (.clk(clk), .rst_n(rst_n), .cfg(cfg), .sample(sample), .cal_pulse_out(cal),
    .slow_pulse_out_a(sa), .slow_pulse_out_b(sb), .reverse_power_flag(flg));
  epoc_counter_model ctr_u (.clk(clk), .rst_n(rst_n), .pulse_a(sa), .pulse_b(sb), .n_steps(steps));
  initial begin
    // bench clock stands in for the oscillator; pulse scaling assumes its nominal rate
    forever #5 clk = ~clk;
  end
  ////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task cmp_cal(input logic [7:0] got, input logic [7:0] exp);
    cmp(got, exp);
  endtask
  task cmp_slow(input logic [7:0] got, input logic [7:0] exp);
    cmp(got, exp);
  endtask
  task cmp_steps(input logic [7:0] got, input logic [7:0] exp);
    cmp(got, exp);
  endtask
  task end_sim;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task put(input logic signed [31:0] p);
    @(negedge clk);
    sample = '{p, 1'b1};
    @(negedge clk);
    sample = '0;
  endtask
  // a huge sample stays applied through reset and must leave no trace
  task rst(input logic [4:0] c);
    @(negedge clk);
    rst_n = 1'b0;
    cfg = c;
    sample = '{32'h7FFFFFFF, 1'b1};
    repeat (5) @(negedge clk);
    sample = '0;
    rst_n = 1'b1;
  endtask
  ////////////////////////////////
  always @(posedge clk) begin
    #1;
    if (cal && !pc) cmp_cal({7'h08, flg}, q.size() ? q.pop_front() : 8'hFF);
    if (!sa && pa) cmp_slow(8'h20, q.size() ? q.pop_front() : 8'hFF);
    if (!sb && pb) cmp_slow(8'h30, q.size() ? q.pop_front() : 8'hFF);
    pc = cal;
    pa = sa;
    pb = sb;
  end
  initial begin
    for (int i = 0; i < 32; i++) begin
      int t;
      t = (1 << (24 - i[3:2] - i[4])) >> (i[1:0] + 32'(i[1]));
      lf = lfsr(lf);
      rst(i[4:0]);
      put(t / 2 + lf % (t / 4));
      q.push_back({7'h08, i[2]});
      put(i[2] ? -t : t);
      repeat (12) @(negedge clk);
    end
    rst(5'h0C);
    q.push_back(8'h10);
    q.push_back(8'h20);
    put(32'h03000000);
    q.push_back(8'h30);
    put(32'h03000000);
    repeat (12) @(negedge clk);
    cmp_steps(steps, 8'h02);
    cmp_slow(8'(q.size()), 8'h00);
    end_sim();
  end
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
